// *** src/sync_params_map.svh ***
// constants of the sync parameter register bank: offsets, fields, fixed values
// assumes a 32-bit apb slave, one register per aligned word
`ifndef SYNC_PARAMS_MAP_SVH
`define SYNC_PARAMS_MAP_SVH

// =====================================================================
// offsets
`define OFF_OUT_DELAY      12'h000
`define OFF_OUT_MISSED     12'h004
`define OFF_OUT_OVERRUN    12'h008
`define OFF_OUT_SHORT      12'h00C
`define OFF_OUT_LATE       12'h010
`define OFF_OUT_COMMAND    12'h014
`define OFF_OUT_SHIFT      12'h018
`define OFF_OUT_MINCYC     12'h01C
`define OFF_OUT_CALC       12'h020
`define OFF_IN_COUNT       12'h040
`define OFF_IN_SELECT      12'h044
`define OFF_IN_PERIOD      12'h048
`define OFF_IN_SHIFT       12'h04C
`define OFF_IN_SUPPORT     12'h050
`define OFF_IN_MINCYC      12'h054
`define OFF_IN_CALC        12'h058
`define OFF_IN_COMMAND     12'h05C
`define OFF_IN_DELAY       12'h060
`define OFF_IN_MISSED      12'h064
`define OFF_IN_OVERRUN     12'h068
`define OFF_IN_SHORT       12'h06C
`define OFF_IN_LATE        12'h070
`define OFF_IRQ_STATUS     12'h080
`define OFF_IRQ_MASK       12'h084

// =====================================================================
// fields and fixed values
`define SUPPORT_BASE       16'h8007
`define SUPPORT_SHIFT_LSB  4
`define SHIFT_LOCAL        2'b01
`define SHIFT_SYNC1        2'b10
`define IN_ENTRY_COUNT     8'h07
`define MODE_FREE          16'h0000
`define MODE_SM_IN         16'h0001
`define MODE_SYNC0         16'h0002
`define MODE_SYNC1         16'h0003
`define MODE_SM_OUT        16'h0022
`define CMD_START          16'h0001
`define CMD_STOP           16'h0000
`define COUNT_MAX          16'hFFFF
`define IRQ_BITS           8

`endif

// *** src/sync_params_pkg.sv ***
// types of the sync parameter register bank
// assumes the map header for numeric constants
package sync_params_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  // one cycle of timing samples from the sync engine
  typedef struct packed {
    logic        valid;
    logic [31:0] outShift;
    logic [31:0] minCycle;
    logic [31:0] outCalc;
    logic [31:0] outDelay;
    logic [31:0] inShift;
    logic [31:0] inCalc;
    logic [31:0] inDelay;
  } timing_sample_t;

  // event pulses, one per cycle
  typedef struct packed {
    logic outMissed;
    logic outOverrun;
    logic outShort;
    logic outLate;
    logic inMissed;
    logic inOverrun;
    logic inShort;
    logic inLate;
  } sync_events_t;

  typedef enum logic [1:0] {
    MEAS_IDLE  = 2'b00,
    MEAS_CLEAR = 2'b01,
    MEAS_RUN   = 2'b10
  } meas_state_t;
endpackage

// *** src/sat_counter.sv ***
// saturating 16-bit event counter
// assumes one increment pulse per clock at most
`timescale 1ns/1ps
`default_nettype none
`include "sync_params_map.svh"
module sat_counter (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        inc,
  output logic [15:0]      count
);
  logic [15:0] countReg;
  logic [15:0] countNext;
  // stick at the top so a flood of errors never reads as few
  assign countNext = (inc && countReg != `COUNT_MAX) ? countReg + 16'h0001
                                                     : countReg;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) countReg <= 16'h0000;
    else countReg <= countNext;
  end
  assign count = countReg;
endmodule
`default_nettype wire

// *** src/max_capture.sv ***
// running maximum of one timing value
// assumes clear and sample never needed in the same cycle
`timescale 1ns/1ps
`default_nettype none
module max_capture (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        clear,
  input  wire logic        sample,
  input  wire logic [31:0] value,
  output logic [31:0]      maxValue
);
  logic [31:0] maxReg;
  logic        bigger;
  assign bigger = sample && (value > maxReg);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) maxReg <= 32'h0000_0000;
    else if (clear) maxReg <= 32'h0000_0000;
    else if (bigger) maxReg <= value;
  end
  assign maxValue = maxReg;
endmodule
`default_nettype wire

// *** src/sync_manager_sync_params.sv ***
// sync parameter register bank of the output and input sync objects
// assumes an apb master and a sync engine delivering samples and events
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sync_params_map.svh"
module sync_manager_sync_params (
  input  wire logic                           clk_sys,
  input  wire logic                           resetn,
  input  wire sync_params_pkg::apb_req_t      apbReq,
  output sync_params_pkg::apb_rsp_t           apbRsp,
  input  wire sync_params_pkg::timing_sample_t sample,
  input  wire sync_params_pkg::sync_events_t  events,
  input  wire logic                           operational,
  input  wire logic                           dcMode,
  input  wire logic                           outputsPresent,
  output logic [15:0]                         inSyncSelect,
  output logic [31:0]                         inSync0Shift,
  output logic [31:0]                         inCyclePeriod,
  output logic                                measureRunning,
  output logic                                irq
);
  import sync_params_pkg::*;

  // ===================================================================
  // bus decode
  logic        wrStb;
  logic        rdStb;
  logic [11:0] addr;
  assign addr  = apbReq.paddr;
  assign wrStb = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign rdStb = apbReq.psel && apbReq.penable && !apbReq.pwrite;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  logic wrSelect;
  logic wrInPeriod;
  logic wrInShift;
  logic wrOutCmd;
  logic wrInCmd;
  logic wrIrqStatus;
  logic wrIrqMask;
  assign wrSelect    = wrStb && hit(addr, `OFF_IN_SELECT);
  assign wrInPeriod  = wrStb && hit(addr, `OFF_IN_PERIOD);
  assign wrInShift   = wrStb && hit(addr, `OFF_IN_SHIFT);
  assign wrOutCmd    = wrStb && hit(addr, `OFF_OUT_COMMAND);
  assign wrInCmd     = wrStb && hit(addr, `OFF_IN_COMMAND);
  assign wrIrqStatus = wrStb && hit(addr, `OFF_IRQ_STATUS);
  assign wrIrqMask   = wrStb && hit(addr, `OFF_IRQ_MASK);

  // ===================================================================
  // writable entries
  logic [15:0] selectReg;
  logic [31:0] periodReg;
  logic [31:0] shiftReg;
  logic [15:0] commandReg;
  logic        cmdWrite;
  logic [15:0] cmdValue;
  logic        modeLegal;
  // both command entries share one register so they read alike
  assign cmdWrite = wrOutCmd || wrInCmd;
  assign cmdValue = apbReq.pwdata[15:0];
  // undefined mode codes are refused and the old mode kept
  assign modeLegal = (apbReq.pwdata[15:0] == `MODE_FREE)
                  || (apbReq.pwdata[15:0] == `MODE_SM_IN)
                  || (apbReq.pwdata[15:0] == `MODE_SYNC0)
                  || (apbReq.pwdata[15:0] == `MODE_SYNC1)
                  || (apbReq.pwdata[15:0] == `MODE_SM_OUT);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      selectReg  <= 16'h0000;
      periodReg  <= 32'h0000_0000;
      shiftReg   <= 32'h0000_0000;
      commandReg <= 16'h0000;
    end else begin
      if (wrSelect && modeLegal) selectReg <= apbReq.pwdata[15:0];
      if (wrInPeriod) periodReg <= apbReq.pwdata;
      if (wrInShift) shiftReg <= apbReq.pwdata;
      if (cmdWrite) commandReg <= cmdValue;
    end
  end
  assign inSyncSelect  = selectReg;
  assign inSync0Shift  = shiftReg;
  assign inCyclePeriod = periodReg;

  // ===================================================================
  // measurement control
  meas_state_t measReg;
  meas_state_t measNext;
  logic        startCmd;
  logic        stopCmd;
  assign startCmd = cmdWrite && (cmdValue == `CMD_START);
  assign stopCmd  = cmdWrite && (cmdValue == `CMD_STOP);

  always_comb begin
    measNext = measReg;
    case (measReg)
      MEAS_IDLE:  if (startCmd) measNext = MEAS_CLEAR;
      MEAS_CLEAR: measNext = stopCmd ? MEAS_IDLE : MEAS_RUN;
      MEAS_RUN: begin
        if (startCmd) measNext = MEAS_CLEAR;
        else if (stopCmd) measNext = MEAS_IDLE;
      end
      default:    measNext = MEAS_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) measReg <= MEAS_IDLE;
    else measReg <= measNext;
  end

  logic clearMax;
  logic takeMax;
  assign clearMax = (measReg == MEAS_CLEAR);
  // samples are only taken once the old maxima are gone
  assign takeMax  = (measReg == MEAS_RUN) && sample.valid;
  assign measureRunning = (measReg != MEAS_IDLE);

  // ===================================================================
  // captured maxima
  logic [31:0] outShiftMax;
  logic [31:0] minCycleMax;
  logic [31:0] outCalcMax;
  logic [31:0] outDelayMax;
  logic [31:0] inShiftMax;
  logic [31:0] inCalcMax;
  logic [31:0] inDelayMax;

  max_capture capOutShift (.clk_sys(clk_sys), .resetn(resetn),
    .clear(clearMax), .sample(takeMax), .value(sample.outShift),
    .maxValue(outShiftMax));
  max_capture capMinCycle (.clk_sys(clk_sys), .resetn(resetn),
    .clear(clearMax), .sample(takeMax), .value(sample.minCycle),
    .maxValue(minCycleMax));
  max_capture capOutCalc (.clk_sys(clk_sys), .resetn(resetn),
    .clear(clearMax), .sample(takeMax), .value(sample.outCalc),
    .maxValue(outCalcMax));
  max_capture capOutDelay (.clk_sys(clk_sys), .resetn(resetn),
    .clear(clearMax), .sample(takeMax && dcMode),
    .value(sample.outDelay), .maxValue(outDelayMax));
  max_capture capInShift (.clk_sys(clk_sys), .resetn(resetn),
    .clear(clearMax), .sample(takeMax), .value(sample.inShift),
    .maxValue(inShiftMax));
  max_capture capInCalc (.clk_sys(clk_sys), .resetn(resetn),
    .clear(clearMax), .sample(takeMax && dcMode),
    .value(sample.inCalc), .maxValue(inCalcMax));
  max_capture capInDelay (.clk_sys(clk_sys), .resetn(resetn),
    .clear(clearMax), .sample(takeMax && dcMode),
    .value(sample.inDelay), .maxValue(inDelayMax));

  // shift entry reads the measured maximum while one exists
  logic [31:0] inShiftView;
  assign inShiftView = (measReg == MEAS_IDLE && inShiftMax == 32'h0)
                       ? shiftReg : inShiftMax;

  // ===================================================================
  // error counters
  logic opDc;
  logic incOutMissed;
  logic incOutOverrun;
  logic incOutShort;
  logic incInMissed;
  logic incInOverrun;
  logic incInShort;
  assign opDc          = operational && dcMode;
  assign incOutMissed  = events.outMissed && opDc;
  assign incInMissed   = events.inMissed && opDc;
  assign incOutOverrun = events.outOverrun && operational;
  assign incInOverrun  = events.inOverrun && operational;
  assign incOutShort   = events.outShort && dcMode;
  assign incInShort    = events.inShort && dcMode;

  logic [15:0] outMissedCnt;
  logic [15:0] outOverrunCnt;
  logic [15:0] outShortCnt;
  logic [15:0] inMissedCnt;
  logic [15:0] inOverrunCnt;
  logic [15:0] inShortCnt;
  sat_counter cntOutMissed (.clk_sys(clk_sys), .resetn(resetn),
    .inc(incOutMissed), .count(outMissedCnt));
  sat_counter cntOutOverrun (.clk_sys(clk_sys), .resetn(resetn),
    .inc(incOutOverrun), .count(outOverrunCnt));
  sat_counter cntOutShort (.clk_sys(clk_sys), .resetn(resetn),
    .inc(incOutShort), .count(outShortCnt));
  sat_counter cntInMissed (.clk_sys(clk_sys), .resetn(resetn),
    .inc(incInMissed), .count(inMissedCnt));
  sat_counter cntInOverrun (.clk_sys(clk_sys), .resetn(resetn),
    .inc(incInOverrun), .count(inOverrunCnt));
  sat_counter cntInShort (.clk_sys(clk_sys), .resetn(resetn),
    .inc(incInShort), .count(inShortCnt));

  // ===================================================================
  // sync error flags, reflect the most recent cycle
  logic outLateReg;
  logic inLateReg;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      outLateReg <= 1'b0;
      inLateReg  <= 1'b0;
    end else if (sample.valid) begin
      outLateReg <= events.outLate && dcMode;
      inLateReg  <= events.inLate && dcMode;
    end
  end

  // ===================================================================
  // interrupts
  logic [7:0] evtVec;
  logic [7:0] statusReg;
  logic [7:0] maskReg;
  assign evtVec = {events.inLate && dcMode, incInShort, incInOverrun,
                   incInMissed, events.outLate && dcMode, incOutShort,
                   incOutOverrun, incOutMissed};
  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      statusReg <= 8'h00;
      maskReg   <= 8'h00;
    end else begin
      statusReg <= (statusReg & ~(wrIrqStatus ? apbReq.pwdata[7:0] : 8'h00))
                   | evtVec;
      if (wrIrqMask) maskReg <= apbReq.pwdata[7:0];
    end
  end
  assign irq = |(statusReg & maskReg);

  // ===================================================================
  // supported modes bitmap
  logic [15:0] supportMap;
  assign supportMap = `SUPPORT_BASE
    | {10'h000, (outputsPresent ? `SHIFT_LOCAL : `SHIFT_SYNC1),
       4'h0};
  logic [15:0] outSupportMap;
  assign outSupportMap = `SUPPORT_BASE;

  // ===================================================================
  // read mux, registered data
  logic [31:0] rdData;
  logic        rdMapped;
  always_comb begin
    rdMapped = 1'b1;
    rdData   = 32'h0000_0000;
    case (addr)
      `OFF_OUT_DELAY:   rdData = outDelayMax;
      `OFF_OUT_MISSED:  rdData = {16'h0000, outMissedCnt};
      `OFF_OUT_OVERRUN: rdData = {16'h0000, outOverrunCnt};
      `OFF_OUT_SHORT:   rdData = {16'h0000, outShortCnt};
      `OFF_OUT_LATE:    rdData = {31'h0, outLateReg};
      `OFF_OUT_COMMAND: rdData = {16'h0000, commandReg};
      `OFF_OUT_SHIFT:   rdData = outShiftMax;
      `OFF_OUT_MINCYC:  rdData = minCycleMax;
      `OFF_OUT_CALC:    rdData = outCalcMax;
      `OFF_IN_COUNT:    rdData = {24'h0, `IN_ENTRY_COUNT};
      `OFF_IN_SELECT:   rdData = {16'h0000, selectReg};
      `OFF_IN_PERIOD:   rdData = periodReg;
      `OFF_IN_SHIFT:    rdData = inShiftView;
      `OFF_IN_SUPPORT:  rdData = {16'h0000, supportMap};
      `OFF_IN_MINCYC:   rdData = minCycleMax;
      `OFF_IN_CALC:     rdData = inCalcMax;
      `OFF_IN_COMMAND:  rdData = {16'h0000, commandReg};
      `OFF_IN_DELAY:    rdData = inDelayMax;
      `OFF_IN_MISSED:   rdData = {16'h0000, inMissedCnt};
      `OFF_IN_OVERRUN:  rdData = {16'h0000, inOverrunCnt};
      `OFF_IN_SHORT:    rdData = {16'h0000, inShortCnt};
      `OFF_IN_LATE:     rdData = {31'h0, inLateReg};
      `OFF_IRQ_STATUS:  rdData = {24'h0, statusReg};
      `OFF_IRQ_MASK:    rdData = {24'h0, maskReg};
      default:          rdMapped = 1'b0;
    endcase
  end

  // zero-wait slave; unmapped addresses answer with pslverr
  logic [31:0] prdataReg;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) prdataReg <= 32'h0000_0000;
    else if (apbReq.psel && !apbReq.penable && !apbReq.pwrite)
      prdataReg <= rdData;
  end

  logic unusedOutMap;
  assign unusedOutMap = |outSupportMap;
  assign apbRsp.prdata  = prdataReg;
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = apbReq.psel && apbReq.penable && !rdMapped;
endmodule
`default_nettype wire

// *** verification/sync_params_chk.sv ***
// checker of the sync parameter bank, sees only the top module ports
// assumes one clock domain and the offsets of the map header
`timescale 1ns/1ps
`default_nettype none
`include "sync_params_map.svh"
module sync_params_chk (
  input wire logic                            clk_sys,
  input wire logic                            resetn,
  input wire sync_params_pkg::apb_req_t       apbReq,
  input wire sync_params_pkg::apb_rsp_t       apbRsp,
  input wire sync_params_pkg::timing_sample_t sample,
  input wire sync_params_pkg::sync_events_t   events,
  input wire logic                            operational,
  input wire logic                            dcMode,
  input wire logic                            outputsPresent,
  input wire logic [15:0]                     inSyncSelect,
  input wire logic [31:0]                     inSync0Shift,
  input wire logic [31:0]                     inCyclePeriod,
  input wire logic                            measureRunning,
  input wire logic                            irq
);
  import sync_params_pkg::*;
  // =========================
  // helper decode
  wire logic acc = apbReq.psel && apbReq.penable;
  wire logic wr = acc && apbReq.pwrite;
  wire logic cmdWr = wr && (apbReq.paddr == `OFF_OUT_COMMAND ||
                            apbReq.paddr == `OFF_IN_COMMAND);
  wire logic selWr = wr && apbReq.paddr == `OFF_IN_SELECT;
  wire logic code = apbReq.pwdata[15:0] inside {16'h0000, 16'h0001,
                    16'h0002, 16'h0003, 16'h0022};
  // a rising irq needs an event or a mask write one cycle before
  wire logic irqCause = (|events) || (wr && apbReq.paddr == `OFF_IRQ_MASK);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // =========================
  // properties
  sequence s_cmd(logic [15:0] v);
    cmdWr && apbReq.pwdata[15:0] == v;
  endsequence
  sequence s_running;
    measureRunning [*2];
  endsequence
  property p_start; s_cmd(16'h0001) |=> s_running; endproperty
  property p_stop; s_cmd(16'h0000) |=> !measureRunning; endproperty
  property p_mode_set;
    selWr && code |=> inSyncSelect == $past(apbReq.pwdata[15:0]);
  endproperty
  property p_mode_keep; (!selWr || !code) |=> $stable(inSyncSelect);
  endproperty
  property p_mode_legal;
    inSyncSelect inside {16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0022};
  endproperty
  property p_shift_set;
    wr && apbReq.paddr == `OFF_IN_SHIFT |=>
      inSync0Shift == $past(apbReq.pwdata);
  endproperty
  property p_period_set;
    wr && apbReq.paddr == `OFF_IN_PERIOD |=>
      inCyclePeriod == $past(apbReq.pwdata);
  endproperty
  property p_ready; apbReq.psel |-> apbRsp.pready; endproperty
  property p_unmapped; acc && apbReq.paddr > `OFF_IRQ_MASK |-> apbRsp.pslverr;
  endproperty
  property p_irq_cause; $rose(irq) |-> $past(irqCause); endproperty

  a_start: assert property (p_start) else $error("no start");
  a_stop: assert property (p_stop) else $error("no stop");
  a_mode_set: assert property (p_mode_set) else $error("mode");
  a_mode_keep: assert property (p_mode_keep) else $error("mode kept");
  a_mode_legal: assert property (p_mode_legal) else $error("code");
  a_shift_set: assert property (p_shift_set) else $error("shift");
  a_period_set: assert property (p_period_set) else $error("period");
  a_ready: assert property (p_ready) else $error("pready low");
  a_unmapped: assert property (p_unmapped) else $error("no pslverr");
  a_irq_cause: assert property (p_irq_cause) else $error("irq cause");
endmodule

bind sync_manager_sync_params sync_params_chk i_sync_params_chk (
  .clk_sys(clk_sys), .resetn(resetn), .apbReq(apbReq), .apbRsp(apbRsp),
  .sample(sample), .events(events), .operational(operational),
  .dcMode(dcMode), .outputsPresent(outputsPresent),
  .inSyncSelect(inSyncSelect), .inSync0Shift(inSync0Shift),
  .inCyclePeriod(inCyclePeriod), .measureRunning(measureRunning),
  .irq(irq));
`default_nettype wire

// *** verification/sync_engine_model.sv ***
// model of the sync engine: timing samples and event pulses
// assumes the bench calls emit and fire right after a clock edge
`timescale 1ns/1ps
`default_nettype none
module sync_engine_model (
  input  wire logic                           clk_sys,
  output var sync_params_pkg::sync_events_t   events,
  output var sync_params_pkg::timing_sample_t sample
);
  import sync_params_pkg::*;
  initial begin
    events = '0;
    sample = '0;
  end
  // off-strobe the values are inverted so a design reading them fails
  task emit(input logic [31:0] v);
    @(posedge clk_sys);
    sample <= {1'b1, v, v + 32'h0000_0001, v + 32'h0000_0002,
               v + 32'h0000_0003, v + 32'h0000_0004, v + 32'h0000_0005,
               v + 32'h0000_0006};
    @(posedge clk_sys);
    sample <= {1'b0, {7{~v}}};
  endtask
  task fire(input sync_events_t e);
    @(posedge clk_sys);
    events <= e;
    @(posedge clk_sys);
    events <= '0;
  endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench of the sync parameter register bank
// assumes the engine model drives samples and event pulses
`timescale 1ns/1ps
`default_nettype none
`include "sync_params_map.svh"
module tb;
  import sync_params_pkg::*;
  logic           clk_sys, resetn, operational, dcMode, outputsPresent;
  logic           e, irq, measureRunning;
  logic [15:0]    inSyncSelect;
  logic [31:0]    inSync0Shift, inCyclePeriod, r;
  apb_req_t       req;
  apb_rsp_t       rsp;
  timing_sample_t sample;
  sync_events_t   events;
  int             errCount, nCompared;
  logic [11:0]    ma [8] = '{12'h018, 12'h01C, 12'h054, 12'h020, 12'h000,
                             12'h04C, 12'h058, 12'h060};
  int             mo [8] = '{0, 1, 1, 2, 3, 4, 5, 6};
  logic [11:0]    ca [6] = '{12'h004, 12'h008, 12'h00C, 12'h064, 12'h068,
                             12'h06C};
  int             cv [6] = '{2, 3, 3, 2, 3, 3};

  sync_manager_sync_params i_sync_manager_sync_params (
    .clk_sys(clk_sys), .resetn(resetn), .apbReq(req), .apbRsp(rsp),
    .sample(sample), .events(events), .operational(operational),
    .dcMode(dcMode), .outputsPresent(outputsPresent),
    .inSyncSelect(inSyncSelect), .inSync0Shift(inSync0Shift),
    .inCyclePeriod(inCyclePeriod), .measureRunning(measureRunning),
    .irq(irq));
  sync_engine_model engine (.clk_sys(clk_sys), .events(events),
                            .sample(sample));

  // =========================
  // bus and compare tasks
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk_sys);
    req.penable <= 1'b1;
    // no local limit: only the watchdog ends a wait for pready
    do @(posedge clk_sys); while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input string nm, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, '0);
    chk(nm, r, x);
  endtask

  // =========================
  // scenarios
  task checkReset;
    for (int i = 0; i < 29; i++) begin
      if (i < 9 || i > 15) begin
        rd("reset", 12'(i * 4), (i == 16) ? 32'h0000_0007 :
           (i == 20) ? 32'h0000_8017 : '0);
      end
    end
    chk("modeOut", inSyncSelect, '0);
    chk("running", measureRunning, '0);
  endtask
  task checkModes;
    logic [15:0] m [5];
    m = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0022};
    for (int i = 0; i < 5; i++) begin
      wr(`OFF_IN_SELECT, {16'h0000, m[i]});
      rd("mode", `OFF_IN_SELECT, {16'h0000, m[i]});
      chk("modeOut", inSyncSelect, {16'h0000, m[i]});
    end
    wr(`OFF_IN_SELECT, 32'h0000_0005);
    rd("badMode", `OFF_IN_SELECT, 32'h0000_0022);
  endtask
  task checkShift;
    wr(`OFF_IN_SHIFT, 32'h1234_5678);
    rd("shift", `OFF_IN_SHIFT, 32'h1234_5678);
    chk("shiftOut", inSync0Shift, 32'h1234_5678);
    wr(`OFF_IN_PERIOD, 32'h0001_86A0);
    rd("period", `OFF_IN_PERIOD, 32'h0001_86A0);
    chk("periodOut", inCyclePeriod, 32'h0001_86A0);
  endtask
  task checkReadOnly;
    wr(`OFF_IN_COUNT, 32'hFFFF_FFFF);
    wr(`OFF_IN_SUPPORT, 32'hFFFF_FFFF);
    wr(`OFF_OUT_MISSED, 32'hFFFF_FFFF);
    rd("count", `OFF_IN_COUNT, 32'h0000_0007);
    rd("support", `OFF_IN_SUPPORT, 32'h0000_8017);
    rd("missedRo", `OFF_OUT_MISSED, '0);
    apb(1'b0, 12'h0F0, '0);
    chk("slvErr", e, 32'h0000_0001);
    chk("slvData", r, '0);
    outputsPresent <= 1'b0;
    rd("supportIn", `OFF_IN_SUPPORT, 32'h0000_8027);
    outputsPresent <= 1'b1;
  endtask
  task maxChk(input logic [31:0] v);
    for (int i = 0; i < 8; i++)
      rd("max", ma[i], v + mo[i]);
  endtask
  task checkMeasure;
    // delay maxima and the input calc maximum are only taken in dc mode
    dcMode <= 1'b1;
    wr(`OFF_OUT_COMMAND, 32'h0000_0001);
    rd("cmd", `OFF_IN_COMMAND, 32'h0000_0001);
    chk("running", measureRunning, 32'h0000_0001);
    engine.emit(32'h0000_0064);
    engine.emit(32'h0000_0032);
    maxChk(32'h0000_0064);
    wr(`OFF_IN_COMMAND, 32'h0000_0001);
    engine.emit(32'h0000_0014);
    maxChk(32'h0000_0014);
    wr(`OFF_OUT_COMMAND, '0);
    @(posedge clk_sys);
    chk("stopped", measureRunning, '0);
    engine.emit(32'h0000_01F4);
    maxChk(32'h0000_0014);
  endtask
  task checkCounters;
    operational <= 1'b1;
    dcMode <= 1'b1;
    engine.fire('1);
    engine.fire('1);
    dcMode <= 1'b0;
    engine.fire('1);
    operational <= 1'b0;
    dcMode <= 1'b1;
    engine.fire('1);
    for (int i = 0; i < 6; i++)
      rd("counter", ca[i], cv[i]);
    // late flags follow the events seen with the sample strobe
    fork
      engine.emit(32'h0000_0001);
      engine.fire(8'h11);
    join
    rd("lateOut", `OFF_OUT_LATE, 32'h0000_0001);
    rd("lateIn", `OFF_IN_LATE, 32'h0000_0001);
    engine.emit(32'h0000_0001);
    rd("lateClear", `OFF_OUT_LATE, '0);
  endtask
  task checkIrq;
    rd("status", `OFF_IRQ_STATUS, 32'h0000_00FF);
    chk("irqMasked", irq, '0);
    wr(`OFF_IRQ_MASK, 32'h0000_0008);
    @(posedge clk_sys);
    chk("irqOn", irq, 32'h0000_0001);
    wr(`OFF_IRQ_STATUS, 32'h0000_0008);
    @(posedge clk_sys);
    chk("irqOff", irq, '0);
    rd("statusW1c", `OFF_IRQ_STATUS, 32'h0000_00F7);
  endtask

  // =========================
  // run control
  task completeRun;
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    errCount++;
    completeRun;
  end
  initial begin
    errCount = 0;
    nCompared = 0;
    resetn = 1'b0;
    req = '0;
    operational = 1'b0;
    dcMode = 1'b0;
    outputsPresent = 1'b1;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    checkReset;
    checkModes;
    checkShift;
    checkReadOnly;
    checkMeasure;
    checkCounters;
    checkIrq;
    completeRun;
  end
endmodule
`default_nettype wire
